//--- rtl/dacr_aux_regs.sv
// Purpose: Auxiliary control register slice of a link deserializer.
// Assumes: Error strobes, pixel tick and adaptive results are on clock.
// Notes:   Chip select and bus pins are synchronised before use.
`timescale 1ns/1ns

// Overview of operation
// - Audio override 0 lets the device pick the divider, 1 uses the field.
// - The three-bit VCO output divide field picks 32, 16, 8, 4, 2, 2, 1, 1.
// - Input override 0 leaves the ratio to the sequencer, 1 uses the field.
// - The two-bit input divide field divides the reference by 1, 2, 4 or 8.
// - Equalizer readback is the manual stages if bypassed, else adaptive.
// - Readback is from the second port when it is selected, else the first.
// - The count enable bit turns link error counting on at 1 and off at 0.
// - With counting on, lock drops when ticked errors reach the threshold.
// - With counting off, lock drops on the first ticked link error.
// - Reverse peripheral mode drives the peripheral data pin as an output.
// - Tristate 1 floats pin while chip select is low; 0 drives it whenever reverse mode is on.
// - Polarity 0 launches on falling and samples on rising edges, 1 swaps.
// - Mode 000 is normal framing; 001, 010, 011 carry 1, 2, 4 fast GPIOs.
// - Mode 110 is forward, 111 reverse fast peripheral; 100, 101 reserved.
// - Second port selected: reads and writes reach it and shared registers.
// - Bypassed, stage one reads back in bits 2:0 and stage two in bits 5:3.
module dacr_aux_regs #(
  parameter logic [6:0] BUS_ADDR = dacr_pkg::BUS_ADDR_DEFAULT
) (
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_b,
  input  wire logic [dacr_pkg::MDIV_W-1:0] auto_audio_div,
  input  wire logic [dacr_pkg::MSEL_W-1:0] clock_loop_sequencer_div,
  input  wire logic [dacr_pkg::EQ_W-1:0]   adaptive_eq_port0,
  input  wire logic [dacr_pkg::EQ_W-1:0]   adaptive_eq_port1,
  input  wire logic                    pixel_tick,
  input  wire logic                    embedded_clock_bit_a_err,
  input  wire logic                    embedded_clock_bit_b_err,
  input  wire logic                    link_control_stream_err,
  input  wire logic                    lock_acquired,
  input  wire logic                    chip_select_pin,
  input  wire logic                    core_peripheral_data,
  output logic [dacr_pkg::MDIV_W-1:0]  audio_div_code,
  output logic [5:0]                   vco_out_div_ratio,
  output logic                         vco_in_div_override,
  output logic [3:0]                   vco_in_div_ratio,
  output logic [dacr_pkg::EQ_W-1:0]    equalizer_setting_port0,
  output logic [dacr_pkg::EQ_W-1:0]    equalizer_setting_port1,
  output logic                         receiver_lock,
  output logic                         peripheral_data_out_pin,
  output logic                         peripheral_data_oe_b,
  output logic                         spi_edge_polarity,
  output logic [2:0]                   fast_gpio_count,
  output logic                         fast_spi_forward,
  output logic                         fast_spi_reverse
);
  import dacr_pkg::*;

  // ==========================================================
  // Decoders
  function automatic logic [5:0] out_div(input logic [MDIV_W-1:0] c);
    unique case (c)
      3'b000:         out_div = 6'h20;
      3'b001:         out_div = 6'h10;
      3'b010:         out_div = 6'h08;
      3'b011:         out_div = 6'h04;
      3'b100, 3'b101: out_div = 6'h02;
      default:        out_div = 6'h01;
    endcase
  endfunction

  function automatic logic [3:0] in_div(input logic [MSEL_W-1:0] c);
    in_div = 4'h1 << c;
  endfunction

  function automatic logic [EQ_W-1:0] eq_mux(input logic [7:0] byp,
                                             input logic [EQ_W-1:0] adapt);
    if (byp[EQ_BYPASS_BIT]) begin
      eq_mux = {byp[EQ_STAGE_TWO_LSB +: STAGE_W],
                byp[EQ_STAGE_ONE_LSB +: STAGE_W]};
    end else begin
      eq_mux = adapt;
    end
  endfunction

  // ==========================================================
  // Bus target
  logic       wr_stb;
  logic [7:0] reg_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  dacr_bus_target #(
    .BUS_ADDR (BUS_ADDR)
  ) u_bus (
    .clock    (clock),
    .rst_b    (rst_b),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe_b (sda_oe_b),
    .wr_stb   (wr_stb),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .rd_data  (rd_data)
  );

  // Open-drain: only ever pulls low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ==========================================================
  // Register storage
  logic [7:0] port_select;
  logic [7:0] audio_div;
  logic [7:0] link_thresh;
  logic [7:0] fast_bc;
  logic [7:0] eq_bypass [2];

  wire sel_p1 = port_select[SECOND_PORT_SELECT_BIT];
  wire sel_p0 = port_select[PORT0_SEL_BIT];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      port_select <= RST_PORT_SELECT;
      audio_div   <= RST_AUDIO_DIV;
      link_thresh <= RST_LINK_THRESH;
      fast_bc     <= RST_FAST_BC;
    end else if (wr_stb) begin
      unique case (reg_addr)
        OFS_PORT_SELECT: port_select <= wr_data & WM_PORT_SELECT;
        OFS_AUDIO_DIV:   audio_div   <= wr_data & WM_AUDIO_DIV;
        OFS_LINK_THRESH: link_thresh <= wr_data & WM_LINK_THRESH;
        OFS_FAST_BC:     fast_bc     <= wr_data & WM_FAST_BC;
        default: begin
        end
      endcase
    end
  end

  // Per-port bypass copies; both may be written in one access
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      wire port_hit = (gp == 0) ? sel_p0 : sel_p1;
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          eq_bypass[gp] <= RST_EQ_BYPASS;
        end else if (wr_stb && reg_addr == OFS_EQ_BYPASS && port_hit) begin
          eq_bypass[gp] <= wr_data & WM_EQ_BYPASS;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read mux
  logic [EQ_W-1:0] eq_now [2];
  assign eq_now[0] = eq_mux(eq_bypass[0], adaptive_eq_port0);
  assign eq_now[1] = eq_mux(eq_bypass[1], adaptive_eq_port1);

  always_comb begin
    unique case (reg_addr)
      OFS_PORT_SELECT: rd_data = port_select;
      OFS_AUDIO_DIV:   rd_data = audio_div;
      OFS_EQ_READBACK: rd_data = {2'b00, eq_now[sel_p1]}
                                 & RM_EQ_READBACK;
      OFS_LINK_THRESH: rd_data = link_thresh;
      OFS_FAST_BC:     rd_data = fast_bc;
      OFS_EQ_BYPASS:   rd_data = eq_bypass[sel_p1];
      default:         rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Clock dividers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      audio_div_code      <= RST_AUDIO_DIV[MDIV_LSB +: MDIV_W];
      vco_out_div_ratio   <= out_div(RST_AUDIO_DIV[MDIV_LSB +: MDIV_W]);
      vco_in_div_override <= 1'b0;
      vco_in_div_ratio    <= in_div(RST_AUDIO_DIV[MSEL_LSB +: MSEL_W]);
    end else begin
      if (audio_div[AUDIO_OVR_BIT]) begin
        audio_div_code    <= audio_div[MDIV_LSB +: MDIV_W];
        vco_out_div_ratio <= out_div(audio_div[MDIV_LSB +: MDIV_W]);
      end else begin
        audio_div_code    <= auto_audio_div;
        vco_out_div_ratio <= out_div(auto_audio_div);
      end
      vco_in_div_override <= audio_div[VCO_IN_OVR_BIT];
      if (audio_div[VCO_IN_OVR_BIT]) begin
        vco_in_div_ratio <= in_div(audio_div[MSEL_LSB +: MSEL_W]);
      end else begin
        vco_in_div_ratio <= in_div(clock_loop_sequencer_div);
      end
    end
  end

  // ==========================================================
  // Equalizer settings to the analog stages
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      equalizer_setting_port0 <= '0;
      equalizer_setting_port1 <= '0;
    end else begin
      equalizer_setting_port0 <= eq_now[0];
      equalizer_setting_port1 <= eq_now[1];
    end
  end

  // ==========================================================
  // Link integrity and lock
  logic [THRESH_W-1:0] err_cnt;
  wire any_err = pixel_tick & (embedded_clock_bit_a_err |
                               embedded_clock_bit_b_err |
                               link_control_stream_err);
  wire cnt_en  = link_thresh[ERR_CNT_EN_BIT];
  wire [THRESH_W-1:0] thresh = link_thresh[THRESH_LSB +: THRESH_W];
  wire [THRESH_W:0]   cnt_nx = {1'b0, err_cnt} + {{THRESH_W{1'b0}}, 1'b1};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      err_cnt       <= '0;
      receiver_lock <= 1'b0;
    end else if (lock_acquired) begin
      err_cnt       <= '0;
      receiver_lock <= 1'b1;
    end else if (receiver_lock && any_err) begin
      if (cnt_en) begin
        err_cnt <= cnt_nx[THRESH_W-1:0];
        if (cnt_nx >= {1'b0, thresh}) begin
          receiver_lock <= 1'b0;
        end
      end else begin
        receiver_lock <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Fast back-channel and peripheral pin
  logic [1:0] cs_sync;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync <= 2'h0;
    end else begin
      cs_sync <= {cs_sync[0], chip_select_pin};
    end
  end

  dacr_bc_mode_e bc_mode;
  assign bc_mode = dacr_bc_mode_e'(fast_bc[BC_MODE_LSB +: 3]);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fast_gpio_count  <= 3'h0;
      fast_spi_forward <= 1'b0;
      fast_spi_reverse <= 1'b0;
    end else begin
      fast_spi_forward <= (bc_mode == DACR_BC_SPI_FWD);
      fast_spi_reverse <= (bc_mode == DACR_BC_SPI_REV);
      unique case (bc_mode)
        DACR_BC_GPIO_1: fast_gpio_count <= 3'h1;
        DACR_BC_GPIO_2: fast_gpio_count <= 3'h2;
        DACR_BC_GPIO_4: fast_gpio_count <= 3'h4;
        // Reserved codes behave as normal framing
        default:        fast_gpio_count <= 3'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      peripheral_data_out_pin <= 1'b0;
      peripheral_data_oe_b    <= 1'b1;
      spi_edge_polarity       <= 1'b0;
    end else begin
      peripheral_data_out_pin <= core_peripheral_data;
      spi_edge_polarity       <= fast_bc[EDGE_POL_BIT];
      if (bc_mode == DACR_BC_SPI_REV &&
          (!fast_bc[TRISTATE_SEL_BIT] || cs_sync[1])) begin
        peripheral_data_oe_b <= 1'b0;
      end else begin
        peripheral_data_oe_b <= 1'b1;
      end
    end
  end

endmodule

//--- include/dacr_pkg.sv
// Purpose: Shared constants for the link auxiliary control register slice.
// Assumes: One device clock; registers reached over the two-wire bus.
// Notes:   Offsets are byte register addresses on the two-wire bus.
package dacr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_PORT_SELECT   = 8'h34;
  localparam logic [7:0] OFS_AUDIO_DIV     = 8'h3a;
  localparam logic [7:0] OFS_EQ_READBACK   = 8'h3b;
  localparam logic [7:0] OFS_LINK_THRESH   = 8'h41;
  localparam logic [7:0] OFS_FAST_BC       = 8'h43;
  localparam logic [7:0] OFS_EQ_BYPASS     = 8'h44;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_PORT_SELECT   = 8'h01;
  localparam logic [7:0] RST_AUDIO_DIV     = 8'h00;
  localparam logic [7:0] RST_LINK_THRESH   = 8'h03;
  localparam logic [7:0] RST_FAST_BC       = 8'h00;
  localparam logic [7:0] RST_EQ_BYPASS     = 8'h60;

  // ==========================================================
  // Writable bit masks and readback mask, reserved bits stay zero
  localparam logic [7:0] WM_PORT_SELECT    = 8'h03;
  localparam logic [7:0] WM_AUDIO_DIV      = 8'hf7;
  localparam logic [7:0] WM_LINK_THRESH    = 8'h1f;
  localparam logic [7:0] WM_FAST_BC        = 8'h1f;
  localparam logic [7:0] WM_EQ_BYPASS      = 8'hef;
  localparam logic [7:0] RM_EQ_READBACK    = 8'h3f;

  // ==========================================================
  // Field positions
  localparam int PORT0_SEL_BIT     = 0;
  localparam int SECOND_PORT_SELECT_BIT     = 1;
  localparam int AUDIO_OVR_BIT     = 7;
  localparam int MDIV_LSB          = 4;
  localparam int VCO_IN_OVR_BIT    = 2;
  localparam int MSEL_LSB          = 0;
  localparam int ERR_CNT_EN_BIT    = 4;
  localparam int THRESH_LSB        = 0;
  localparam int TRISTATE_SEL_BIT  = 4;
  localparam int EDGE_POL_BIT      = 3;
  localparam int BC_MODE_LSB       = 0;
  localparam int EQ_STAGE_ONE_LSB  = 5;
  localparam int EQ_STAGE_TWO_LSB  = 1;
  localparam int EQ_BYPASS_BIT     = 0;

  localparam int MDIV_W   = 3;
  localparam int MSEL_W   = 2;
  localparam int THRESH_W = 4;
  localparam int EQ_W     = 6;
  localparam int STAGE_W  = 3;

  // ==========================================================
  // Fast back-channel modes
  typedef enum logic [2:0] {
    DACR_BC_NORMAL   = 3'b000,
    DACR_BC_GPIO_1   = 3'b001,
    DACR_BC_GPIO_2   = 3'b010,
    DACR_BC_GPIO_4   = 3'b011,
    DACR_BC_RSVD_A   = 3'b100,
    DACR_BC_RSVD_B   = 3'b101,
    DACR_BC_SPI_FWD  = 3'b110,
    DACR_BC_SPI_REV  = 3'b111
  } dacr_bc_mode_e;

  // Two-wire target address; arbitrary default
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2c;

endpackage

//--- rtl/dacr_bus_target.sv
// Purpose: Two-wire bus target giving byte register reads and writes.
// Assumes: Bus pins are asynchronous and pass two flops before use.
// Notes:   Register pointer auto-increments after each written byte and each acknowledged read byte.
`timescale 1ns/1ns
module dacr_bus_target #(
  parameter logic [6:0] BUS_ADDR = 7'h2c
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe_b,
  output logic            wr_stb,
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);

  typedef enum logic [3:0] {
    DACR_ST_IDLE    = 4'b0000,
    DACR_ST_ADDR    = 4'b0001,
    DACR_ST_ACK_ADR = 4'b0010,
    DACR_ST_REG     = 4'b0011,
    DACR_ST_ACK_REG = 4'b0100,
    DACR_ST_WDATA   = 4'b0101,
    DACR_ST_ACK_WR  = 4'b0110,
    DACR_ST_RDATA   = 4'b0111,
    DACR_ST_RACK    = 4'b1000
  } dacr_bus_st_e;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;

  // ==========================================================
  // Pin synchronisers
  logic [1:0]   scl_sync;
  logic [1:0]   sda_sync;
  logic         scl_prev;
  logic         sda_prev;
  dacr_bus_st_e state;
  logic [3:0]   bit_cnt;
  logic [7:0]   shreg;
  logic [7:0]   tx;
  logic         rd_mode;
  logic         nack;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  wire scl_s    = scl_sync[1];
  wire sda_s    = sda_sync[1];
  wire start_ev = scl_s & scl_prev & sda_prev & ~sda_s;
  wire stop_ev  = scl_s & scl_prev & ~sda_prev & sda_s;
  wire scl_rise = scl_s & ~scl_prev;
  wire scl_fall = ~scl_s & scl_prev;

  // ==========================================================
  // Protocol engine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state    <= DACR_ST_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      rd_mode  <= 1'b0;
      nack     <= 1'b0;
      sda_oe_b <= 1'b1;
      wr_stb   <= 1'b0;
      wr_data  <= 8'h00;
      reg_addr <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_ev) begin
        state    <= DACR_ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_b <= 1'b1;
      end else if (stop_ev) begin
        state    <= DACR_ST_IDLE;
        sda_oe_b <= 1'b1;
      end else if (scl_rise) begin
        unique case (state)
          DACR_ST_ADDR, DACR_ST_REG, DACR_ST_WDATA: begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          DACR_ST_RACK: begin
            nack <= sda_s;
            if (!sda_s) begin
              reg_addr <= reg_addr + 8'h01;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state)
          DACR_ST_ADDR: begin
            if (bit_cnt == BYTE_BITS) begin
              if (shreg[7:1] == BUS_ADDR) begin
                state    <= DACR_ST_ACK_ADR;
                rd_mode  <= shreg[0];
                sda_oe_b <= 1'b0;
              end else begin
                state <= DACR_ST_IDLE;
              end
            end
          end
          DACR_ST_ACK_ADR: begin
            bit_cnt <= 4'h0;
            if (rd_mode) begin
              state    <= DACR_ST_RDATA;
              tx       <= {rd_data[6:0], 1'b0};
              sda_oe_b <= rd_data[7];
            end else begin
              state    <= DACR_ST_REG;
              sda_oe_b <= 1'b1;
            end
          end
          DACR_ST_REG: begin
            if (bit_cnt == BYTE_BITS) begin
              reg_addr <= shreg;
              state    <= DACR_ST_ACK_REG;
              sda_oe_b <= 1'b0;
            end
          end
          DACR_ST_ACK_REG: begin
            state    <= DACR_ST_WDATA;
            bit_cnt  <= 4'h0;
            sda_oe_b <= 1'b1;
          end
          DACR_ST_WDATA: begin
            if (bit_cnt == BYTE_BITS) begin
              wr_stb   <= 1'b1;
              wr_data  <= shreg;
              state    <= DACR_ST_ACK_WR;
              sda_oe_b <= 1'b0;
            end
          end
          DACR_ST_ACK_WR: begin
            state    <= DACR_ST_WDATA;
            bit_cnt  <= 4'h0;
            reg_addr <= reg_addr + 8'h01;
            sda_oe_b <= 1'b1;
          end
          DACR_ST_RDATA: begin
            if (bit_cnt == LAST_BIT) begin
              state    <= DACR_ST_RACK;
              sda_oe_b <= 1'b1;
            end else begin
              bit_cnt  <= bit_cnt + 4'h1;
              sda_oe_b <= tx[7];
              tx       <= {tx[6:0], 1'b0};
            end
          end
          DACR_ST_RACK: begin
            if (nack) begin
              state <= DACR_ST_IDLE;
            end else begin
              state    <= DACR_ST_RDATA;
              bit_cnt  <= 4'h0;
              tx       <= {rd_data[6:0], 1'b0};
              sda_oe_b <= rd_data[7];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule

//--- sim/dacr_aux_regs_properties.sv
// Purpose: Port assertions for the aux register slice.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to the top module after the checker.
`timescale 1ns/1ns
module dacr_aux_regs_checker (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       lock_acquired,
  input wire logic       embedded_clock_bit_a_err,
  input wire logic       embedded_clock_bit_b_err,
  input wire logic       link_control_stream_err,
  input wire logic       receiver_lock,
  input wire logic [5:0] vco_out_div_ratio,
  input wire logic [3:0] vco_in_div_ratio,
  input wire logic       core_peripheral_data,
  input wire logic       peripheral_data_out_pin,
  input wire logic       peripheral_data_oe_b,
  input wire logic [2:0] fast_gpio_count,
  input wire logic       fast_spi_forward,
  input wire logic       fast_spi_reverse
);
  wire any_err = embedded_clock_bit_a_err | embedded_clock_bit_b_err |
                 link_control_stream_err;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Link lock
  sequence s_acq;
    lock_acquired && !any_err;
  endsequence
  // Two quiet cycles first, since a drop lags its error
  sequence s_quiet;
    receiver_lock && !any_err && !$past(any_err) && !$past(any_err, 2);
  endsequence
  AST_LOCK_SET: assert property (s_acq |=> receiver_lock)
    else $error("lock not taken after acquire");
  AST_LOCK_HOLD: assert property (s_quiet |=> receiver_lock)
    else $error("lock lost without link error");
  // ==========================================================
  // Dividers and back-channel
  AST_VCO_OUT: assert property (
    vco_out_div_ratio inside {32, 16, 8, 4, 2, 1})
    else $error("illegal output divide ratio");
  AST_VCO_IN: assert property ($onehot(vco_in_div_ratio))
    else $error("illegal input divide ratio");
  AST_SPI_EXCL: assert property (
    !(fast_spi_forward && fast_spi_reverse))
    else $error("both fast peripheral directions on");
  AST_GPIO: assert property (fast_gpio_count != 0 |->
    fast_gpio_count inside {1, 2, 4} && !fast_spi_forward && !fast_spi_reverse)
    else $error("bad fast gpio mode");
  AST_OE_REV: assert property (
    !peripheral_data_oe_b |-> fast_spi_reverse)
    else $error("pin driven outside reverse mode");
  AST_PIN: assert property (!peripheral_data_oe_b |->
    peripheral_data_out_pin == $past(core_peripheral_data))
    else $error("driven pin does not follow core data");
endmodule

bind dacr_aux_regs dacr_aux_regs_checker u_chk (
  .clock(clock), .rst_b(rst_b), .lock_acquired(lock_acquired),
  .embedded_clock_bit_a_err(embedded_clock_bit_a_err),
  .embedded_clock_bit_b_err(embedded_clock_bit_b_err),
  .link_control_stream_err(link_control_stream_err),
  .receiver_lock(receiver_lock), .vco_out_div_ratio(vco_out_div_ratio),
  .vco_in_div_ratio(vco_in_div_ratio),
  .core_peripheral_data(core_peripheral_data),
  .peripheral_data_out_pin(peripheral_data_out_pin),
  .peripheral_data_oe_b(peripheral_data_oe_b),
  .fast_gpio_count(fast_gpio_count), .fast_spi_forward(fast_spi_forward),
  .fast_spi_reverse(fast_spi_reverse)
);

//--- sim/dacr_link_partner.sv
// Purpose: Far-end link model giving pixel ticks, errors and lock.
// Assumes: Errors are only sent in pixel tick cycles.
// Notes:   Error source rotates over the monitored streams.
`timescale 1ns/1ns
module dacr_link_partner (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       relock,
  input  wire logic [3:0] add,
  output logic            pixel_tick,
  output logic [2:0]      err,
  output logic            lock_acquired
);
  logic [3:0] left;
  // ==========================================================
  // Link events
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pixel_tick <= 1'b0;
      err <= 3'h0;
      left <= 4'h0;
      lock_acquired <= 1'b0;
    end else begin
      pixel_tick <= ~pixel_tick;
      lock_acquired <= relock;
      err <= 3'h0;
      if (add != 4'h0) begin
        left <= add;
      end else if (!pixel_tick && left != 4'h0) begin
        err <= 3'(1 << left % 3);
        left <= left - 4'h1;
      end
    end
  end
endmodule

//--- sim/tb_dacr_aux_regs.sv
// Purpose: Self-checking bench for the aux register slice.
// Assumes: Two-wire master bit-banged here, slow enough for the syncs.
// Notes:   Link errors come from the partner model.
`timescale 1ns/1ns
module tb_dacr_aux_regs;
  import dacr_pkg::*;
  localparam logic [7:0] RT [8] = '{32, 16, 8, 4, 2, 2, 1, 1};
  localparam logic [7:0] GP [8] = '{0, 1, 2, 4, 0, 0, 0, 0};
  logic       clock = 0, rst_b = 0, scl = 1, sdm = 1, cs = 0, relock = 0;
  logic       cd = 0;
  logic [3:0] add = 0, iratio;
  logic       pt, la, lock, oe_b, fwd, rev, pol, pin, sdo, sda_oe_b, ovr;
  logic [2:0] err, adiv, gpio;
  logic [5:0] oratio, eq0, eq1;
  int         errors = 0, n_checks = 0;
  wire        sda = sdm & (sda_oe_b | sdo);
  initial forever #4 clock = ~clock;
  dacr_link_partner u_far (.clock(clock), .rst_b(rst_b), .relock(relock),
    .add(add), .pixel_tick(pt), .err(err), .lock_acquired(la));
  dacr_aux_regs u_dut (.clock(clock), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(sdo), .sda_oe_b(sda_oe_b),
    .auto_audio_div(3'h5), .clock_loop_sequencer_div(2'h2),
    .adaptive_eq_port0(6'h2a), .adaptive_eq_port1(6'h33),
    .pixel_tick(pt), .embedded_clock_bit_a_err(err[0]),
    .embedded_clock_bit_b_err(err[1]), .link_control_stream_err(err[2]),
    .lock_acquired(la), .chip_select_pin(cs), .core_peripheral_data(cd),
    .audio_div_code(adiv), .vco_out_div_ratio(oratio),
    .vco_in_div_override(ovr), .vco_in_div_ratio(iratio),
    .equalizer_setting_port0(eq0), .equalizer_setting_port1(eq1),
    .receiver_lock(lock), .peripheral_data_out_pin(pin),
    .peripheral_data_oe_b(oe_b), .spi_edge_polarity(pol),
    .fast_gpio_count(gpio), .fast_spi_forward(fwd), .fast_spi_reverse(rev));
  // ==========================================================
  // Bus tasks
  task automatic hc(int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bt(logic b, output logic r);
    sdm <= b;
    hc(4);
    scl <= 1;
    hc(6);
    r = sda;
    scl <= 0;
    hc(3);
  endtask
  task automatic st();
    sdm <= 1;
    hc(3);
    scl <= 1;
    hc(6);
    sdm <= 0;
    hc(6);
    scl <= 0;
    hc(3);
  endtask
  task automatic sp();
    sdm <= 0;
    hc(3);
    scl <= 1;
    hc(6);
    sdm <= 1;
    hc(6);
  endtask
  task automatic xb(logic [7:0] d, logic ea, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(1'b1, a);
    chk("ack", 8'(ea), 8'(!a));
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [7:0] q;
    st();
    xb({BUS_ADDR_DEFAULT, 1'b0}, 1, q);
    xb(a, 1, q);
    xb(d, 1, q);
    sp();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    logic [7:0] q;
    st();
    xb({BUS_ADDR_DEFAULT, 1'b0}, 1, q);
    xb(a, 1, q);
    st();
    xb({BUS_ADDR_DEFAULT, 1'b1}, 1, q);
    xb(8'hff, 0, q);
    chk($sformatf("reg %h", a), e, q);
    sp();
  endtask
  task automatic rl();
    relock <= 1;
    hc(1);
    relock <= 0;
    hc(3);
  endtask
  task automatic ers(logic [3:0] n);
    add <= n;
    hc(1);
    add <= 0;
    hc(20);
  endtask
  task automatic finish_test();
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    hc(3);
    rst_b <= 1;
    hc(4);
    rd(OFS_AUDIO_DIV, 8'h00);
    rd(OFS_LINK_THRESH, 8'h03);
    rd(8'h50, 8'h00);
    rd(OFS_EQ_READBACK, 8'h2a);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_AUDIO_DIV, 8'(8'h8c | k << 4 | k % 4));
      chk("out_div", RT[k], 8'(oratio));
      chk("aud_div", 8'(k), 8'(adiv));
      chk("in_div", 8'(1 << k % 4), 8'(iratio));
      chk("ovr", 8'h01, 8'(ovr));
      rd(OFS_AUDIO_DIV, 8'(8'h84 | k << 4 | k % 4));
    end
    wr(OFS_AUDIO_DIV, 8'h00);
    chk("aud_auto", 8'h05, 8'(adiv));
    chk("in_auto", 8'h04, 8'(iratio));
    chk("ovr", 8'h00, 8'(ovr));
    wr(OFS_EQ_BYPASS, 8'hb5);
    rd(OFS_EQ_READBACK, 8'h15);
    chk("eq0", 8'h15, 8'(eq0));
    chk("eq1", 8'h33, 8'(eq1));
    wr(OFS_PORT_SELECT, 8'h02);
    rd(OFS_EQ_READBACK, 8'h33);
    rd(OFS_EQ_BYPASS, 8'h60);
    wr(OFS_PORT_SELECT, 8'h01);
    rl();
    chk("lock", 8'h01, 8'(lock));
    wr(OFS_LINK_THRESH, 8'hf3);
    rd(OFS_LINK_THRESH, 8'h13);
    ers(2);
    chk("lock", 8'h01, 8'(lock));
    ers(1);
    chk("lock", 8'h00, 8'(lock));
    rl();
    chk("lock", 8'h01, 8'(lock));
    wr(OFS_LINK_THRESH, 8'h03);
    ers(1);
    chk("lock", 8'h00, 8'(lock));
    for (int j = 0; j < 8; j++) begin
      wr(OFS_FAST_BC, 8'(8'he0 | j));
      chk("gpio", GP[j], 8'(gpio));
      chk("spi", 8'({j == 6, j == 7}), 8'({fwd, rev}));
      chk("oe", 8'(j != 7), 8'(oe_b));
      chk("pol", 8'h00, 8'(pol));
    end
    wr(OFS_FAST_BC, 8'h1f);
    rd(OFS_FAST_BC, 8'h1f);
    chk("oe", 8'h01, 8'(oe_b));
    chk("pol", 8'h01, 8'(pol));
    cs <= 1;
    cd <= 1;
    hc(6);
    chk("oe", 8'h00, 8'(oe_b));
    chk("pin", 8'h01, 8'(pin));
    finish_test();
  end
endmodule
